// [rtl/tpwm_pkg.sv]
package tpwm_pkg;

  localparam int unsigned DW = 16;
  localparam int unsigned AW = 8;
  localparam int unsigned NPHASE = 3;

  // register offsets
  localparam logic [7:0] OFS_PERIOD = 8'h00;
  localparam logic [7:0] OFS_DEAD = 8'h04;
  localparam logic [7:0] OFS_DUTY0 = 8'h08;
  localparam logic [7:0] OFS_DUTY1 = 8'h0c;
  localparam logic [7:0] OFS_DUTY2 = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // field positions
  localparam int unsigned CTRL_DOUBLE_BIT = 0;
  localparam int unsigned STATE_HALF_BIT = 0;
  localparam int unsigned STATE_RUN_BIT = 1;
  localparam int unsigned STATE_OUT_EN_BIT = 2;
  localparam int unsigned IRQ_SYNC_BIT = 0;
  localparam int unsigned IRQ_HALF_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  // reset values
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] DEAD_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [3:0] WRITTEN_ALL = 4'hf;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tpwm_bus_s;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] dead;
    logic [2:0][15:0] duty;
    logic [15:0] act_period;
    logic [15:0] act_dead;
    logic [2:0][15:0] act_duty;
    logic double_mode;
    logic [3:0] written;
    logic started;
    logic half;
    logic [15:0] cnt;
    logic sync;
    logic [2:0] high;
    logic [2:0] low;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
  } tpwm_state_s;

endpackage

// [rtl/tpwm_timing_unit.sv]
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module tpwm_timing_unit
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // power stage drives
  output logic o_phase0_high_out,
  output logic o_phase0_low_out,
  output logic o_phase1_high_out,
  output logic o_phase1_low_out,
  output logic o_phase2_high_out,
  output logic o_phase2_low_out,
  // sync and interrupt
  output logic o_period_sync_pulse,
  output logic o_half_cycle,
  output logic o_irq
);

  //////////////////////////////////////////////////////////////////////////////

  tpwm_pkg::tpwm_bus_s bus;
  tpwm_pkg::tpwm_state_s s;
  tpwm_pkg::tpwm_state_s next_s;

  logic [15:0] last_cnt;
  logic half_end;
  logic out_en;
  logic ev_sync;
  logic ev_half;
  logic load_shadow;
  logic [15:0] on_high;
  logic [15:0] on_low;
  logic [15:0] rise_high;
  logic [15:0] rise_low;

  assign bus.addr = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr = i_wr;
  assign bus.rd = i_rd;

  //////////////////////////////////////////////////////////////////////////////

  // on time within one half, clamped to [0, half length]
  // nineteen signed bits keep the sum from wrapping before the clamp
  function automatic logic [15:0] half_on
  (
    input logic [15:0] per,
    input logic [15:0] duty,
    input logic [15:0] dead,
    input logic high_side
  );
    logic signed [18:0] base;
    logic signed [18:0] raw;
    base = $signed({4'h0, per[15:1]});
    if (high_side)
    begin
      raw = base + $signed({3'h0, duty}) - $signed({3'h0, dead});
    end
    else
    begin
      raw = base - $signed({3'h0, duty}) - $signed({3'h0, dead});
    end
    if (raw < 19'sh0)
    begin
      half_on = 16'h0000;
    end
    else if (raw > $signed({3'h0, per}))
    begin
      half_on = per;
    end
    else
    begin
      half_on = raw[15:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_s = s;
    next_s.sync = 1'b0;
    next_s.rdata = 32'h0000_0000;
    ev_sync = 1'b0;
    ev_half = 1'b0;
    load_shadow = 1'b0;
    on_high = 16'h0000;
    on_low = 16'h0000;
    rise_high = 16'h0000;
    rise_low = 16'h0000;

    // a zero period runs as one, so the counter never stalls
    if (s.act_period == 16'h0000)
    begin
      last_cnt = 16'h0000;
    end
    else
    begin
      last_cnt = s.act_period - 16'h0001;
    end
    half_end = s.started && (s.cnt >= last_cnt);
    // outputs only once period and all duty values are written
    out_en = s.started && (s.written == tpwm_pkg::WRITTEN_ALL);

    // register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        tpwm_pkg::OFS_PERIOD:
        begin
          next_s.period = bus.wdata[15:0];
          next_s.written[0] = 1'b1;
          // first period write starts the main timer
          if (!s.started)
          begin
            next_s.started = 1'b1;
            // shadows take the values so far; later writes wait for a reload
            next_s.act_period = bus.wdata[15:0];
            next_s.act_dead = s.dead;
            next_s.act_duty = s.duty;
            if (s.double_mode)
            begin
              // begin at the second half, sync after one period value
              next_s.half = 1'b1;
              next_s.cnt = 16'h0000;
            end
            else
            begin
              // begin mid first half, sync after 1.5 period values
              next_s.half = 1'b0;
              next_s.cnt = {1'b0, bus.wdata[15:1]};
            end
          end
        end
        tpwm_pkg::OFS_DEAD:
        begin
          next_s.dead = bus.wdata[15:0];
        end
        tpwm_pkg::OFS_DUTY0:
        begin
          next_s.duty[0] = bus.wdata[15:0];
          next_s.written[1] = 1'b1;
        end
        tpwm_pkg::OFS_DUTY1:
        begin
          next_s.duty[1] = bus.wdata[15:0];
          next_s.written[2] = 1'b1;
        end
        tpwm_pkg::OFS_DUTY2:
        begin
          next_s.duty[2] = bus.wdata[15:0];
          next_s.written[3] = 1'b1;
        end
        tpwm_pkg::OFS_CTRL:
        begin
          next_s.double_mode = bus.wdata[tpwm_pkg::CTRL_DOUBLE_BIT];
        end
        tpwm_pkg::OFS_IRQ_MASK:
        begin
          next_s.irq_mask = bus.wdata[tpwm_pkg::IRQ_W-1:0];
        end
        // unmapped and read-only offsets ignore writes
        default:
        begin
          next_s.period = next_s.period;
        end
      endcase
    end

    // half-period counting
    if (s.started && !(bus.wr && bus.addr == tpwm_pkg::OFS_PERIOD && !s.started))
    begin
      if (half_end)
      begin
        next_s.cnt = 16'h0000;
        // toggle half indicator at each half boundary
        next_s.half = ~s.half;
        ev_half = 1'b1;
        if (s.half)
        begin
          // one sync pulse at the start of each switching period
          ev_sync = 1'b1;
          next_s.sync = 1'b1;
        end
        // double update reloads at the half point as well
        load_shadow = s.double_mode || s.half;
      end
      else
      begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end

    // each half runs for the period value then in force
    if (load_shadow)
    begin
      next_s.act_period = next_s.period;
      next_s.act_dead = next_s.dead;
      next_s.act_duty = next_s.duty;
    end

    // every phase uses the same edge rules with its own duty value
    for (int k = 0; k < tpwm_pkg::NPHASE; k++)
    begin
      // high side gains duty minus dead time per half
      // per-half terms use the values in force during that half
      on_high = half_on(s.act_period, s.act_duty[k], s.act_dead, 1'b1);
      on_low = half_on(s.act_period, s.act_duty[k], s.act_dead, 1'b0);
      rise_high = s.act_period - on_high;
      rise_low = s.act_period - on_low;
      // outputs follow the counter state of the cycle before, one cycle behind
      // dead time trims both edges of each side equally
      // the same insertion holds in double update mode
      if (!s.half)
      begin
        next_s.high[k] = out_en && (s.cnt >= rise_high);
        next_s.low[k] = out_en && (s.cnt < on_low);
      end
      else
      begin
        next_s.high[k] = out_en && (s.cnt < on_high);
        next_s.low[k] = out_en && (s.cnt >= rise_low);
      end
    end

    // register reads
    if (bus.rd)
    begin
      unique case (bus.addr)
        tpwm_pkg::OFS_PERIOD:
        begin
          next_s.rdata = {16'h0000, s.period};
        end
        tpwm_pkg::OFS_DEAD:
        begin
          next_s.rdata = {16'h0000, s.dead};
        end
        tpwm_pkg::OFS_DUTY0:
        begin
          next_s.rdata = {16'h0000, s.duty[0]};
        end
        tpwm_pkg::OFS_DUTY1:
        begin
          next_s.rdata = {16'h0000, s.duty[1]};
        end
        tpwm_pkg::OFS_DUTY2:
        begin
          next_s.rdata = {16'h0000, s.duty[2]};
        end
        tpwm_pkg::OFS_CTRL:
        begin
          next_s.rdata = {31'h0000_0000, s.double_mode};
        end
        tpwm_pkg::OFS_STATE:
        begin
          // bit 0 shows the current half of the period
          next_s.rdata = 32'h0000_0000;
          next_s.rdata[tpwm_pkg::STATE_HALF_BIT] = s.half;
          next_s.rdata[tpwm_pkg::STATE_RUN_BIT] = s.started;
          next_s.rdata[tpwm_pkg::STATE_OUT_EN_BIT] = out_en;
        end
        tpwm_pkg::OFS_IRQ_STAT:
        begin
          next_s.rdata = {30'h0000_0000, s.irq_stat};
          next_s.irq_stat = 2'h0;
        end
        tpwm_pkg::OFS_IRQ_MASK:
        begin
          next_s.rdata = {30'h0000_0000, s.irq_mask};
        end
        default:
        begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // sticky events, a set in the clearing cycle wins
    if (ev_sync)
    begin
      next_s.irq_stat[tpwm_pkg::IRQ_SYNC_BIT] = 1'b1;
    end
    if (ev_half)
    begin
      next_s.irq_stat[tpwm_pkg::IRQ_HALF_BIT] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s.period <= tpwm_pkg::PERIOD_RST;
      s.dead <= tpwm_pkg::DEAD_RST;
      s.duty <= {3{tpwm_pkg::DUTY_RST}};
      s.act_period <= tpwm_pkg::PERIOD_RST;
      s.act_dead <= tpwm_pkg::DEAD_RST;
      s.act_duty <= {3{tpwm_pkg::DUTY_RST}};
      s.double_mode <= 1'b0;
      s.written <= 4'h0;
      s.started <= 1'b0;
      s.half <= 1'b0;
      s.cnt <= 16'h0000;
      s.sync <= 1'b0;
      s.high <= 3'h0;
      s.low <= 3'h0;
      s.irq_stat <= 2'h0;
      s.irq_mask <= tpwm_pkg::IRQ_MASK_RST;
      s.rdata <= 32'h0000_0000;
    end
    // clock enable low holds every field, read data included
    else if (i_ce)
    begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign o_rdata = s.rdata;
  assign o_phase0_high_out = s.high[0];
  assign o_phase0_low_out = s.low[0];
  assign o_phase1_high_out = s.high[1];
  assign o_phase1_low_out = s.low[1];
  assign o_phase2_high_out = s.high[2];
  assign o_phase2_low_out = s.low[2];
  assign o_period_sync_pulse = s.sync;
  assign o_half_cycle = s.half;
  assign o_irq = |(s.irq_stat & s.irq_mask);

endmodule

// [verification/tpwm_asserts.sv]
`timescale 1ns/1ns
module tpwm_chk
(
  // clock, reset, register port
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // drives and timing
  input wire logic o_phase0_high_out,
  input wire logic o_phase0_low_out,
  input wire logic o_phase1_high_out,
  input wire logic o_phase1_low_out,
  input wire logic o_phase2_high_out,
  input wire logic o_phase2_low_out,
  input wire logic o_period_sync_pulse,
  input wire logic o_half_cycle
);
  logic [3:0] seen;
  logic [5:0] drv;
  logic sync;
  assign drv = {o_phase2_high_out, o_phase1_high_out, o_phase0_high_out,
    o_phase2_low_out, o_phase1_low_out, o_phase0_low_out};
  assign sync = o_period_sync_pulse;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      seen <= 4'h0;
    else if (i_wr)
    begin
      case (i_addr)
        tpwm_pkg::OFS_PERIOD: seen[0] <= 1'b1;
        tpwm_pkg::OFS_DUTY0: seen[1] <= 1'b1;
        tpwm_pkg::OFS_DUTY1: seen[2] <= 1'b1;
        tpwm_pkg::OFS_DUTY2: seen[3] <= 1'b1;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sync_one_cycle_a: assert property (sync |=> !sync)
    else $error("sync pulse too long");
  sync_half_a: assert property (sync |-> $fell(o_half_cycle))
    else $error("sync without half change");
  half_wrap_a: assert property ($fell(o_half_cycle) |-> sync)
    else $error("half change without sync");
  gate_out_a: assert property (seen != 4'hf |-> drv == 6'h0)
    else $error("drive before all values written");
  no_early_sync_a: assert property (!seen[0] |-> !sync)
    else $error("sync before period write");
  no_overlap_a: assert property ((drv[5:3] & drv[2:0]) == 3'h0)
    else $error("high and low side both on");
  state_read_a: assert property ($past(i_rd && i_addr == tpwm_pkg::OFS_STATE) |->
    o_rdata[0] == $past(o_half_cycle) && o_rdata[31:3] == 29'h0)
    else $error("state half bit wrong");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read cycle");
  cover property (sync);
  cover property ($rose(o_half_cycle));
  cover property ($rose(o_phase0_high_out));
endmodule
bind tpwm_timing_unit tpwm_chk CHK (.i_clk, .i_reset, .i_addr, .i_wr, .i_rd, .o_rdata,
  .o_phase0_high_out, .o_phase0_low_out, .o_phase1_high_out, .o_phase1_low_out,
  .o_phase2_high_out, .o_phase2_low_out, .o_period_sync_pulse, .o_half_cycle);

// [verification/tpwm_gate_model.sv]
`timescale 1ns/1ns
module tpwm_gate_model
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // drives from the timing unit
  input wire logic i_sync,
  input wire logic [5:0] i_drv,
  // on cycles of the last period, overlap flag
  output logic [5:0][15:0] o_on,
  output logic o_done,
  output logic o_fault
);
  logic [5:0][15:0] acc;
  always_ff @(posedge i_clk)
  begin
    o_done <= i_sync;
    o_fault <= !i_reset && (o_fault || (i_drv[5:3] & i_drv[2:0]) != 3'h0);
    for (int k = 0; k < 6; k++)
    begin
      acc[k] <= i_sync ? 16'h0 : acc[k] + 16'(i_drv[k]);
      o_on[k] <= i_sync ? acc[k] + 16'(i_drv[k]) : o_on[k];
    end
  end
endmodule

// [verification/tpwm_timing_unit_bench.sv]
`timescale 1ns/1ns
module tpwm_timing_unit_bench;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  tpwm_pkg::tpwm_bus_s bus = '0;
  logic [31:0] rdata;
  logic [5:0] drv;
  logic [5:0][15:0] on;
  logic sync, half, irq, done, fault;
  logic rd_d = 1'b0;
  logic ce = 1'b1;
  logic [31:0] seed = 32'h14;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int w, s;
  logic [31:0] q_rd[$];
  int q_sync[$];
  logic [5:0][15:0] q_on[$];
  tpwm_timing_unit DUT (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_addr(bus.addr),
    .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .o_rdata(rdata),
    .o_phase0_high_out(drv[3]), .o_phase0_low_out(drv[0]), .o_phase1_high_out(drv[4]),
    .o_phase1_low_out(drv[1]), .o_phase2_high_out(drv[5]), .o_phase2_low_out(drv[2]),
    .o_period_sync_pulse(sync), .o_half_cycle(half), .o_irq(irq));
  tpwm_gate_model GATE (.i_clk(i_clk), .i_reset(i_reset), .i_sync(sync), .i_drv(drv),
    .o_on(on), .o_done(done), .o_fault(fault));
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ont(int p, int d, int t, int g);
    int v;
    v = p / 2 + g * d - t;
    return v < 0 ? 0 : (v > p ? p : v);
  endfunction
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge i_clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge i_clk);
    w = cyc;
    bus <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge i_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    q_rd.push_back(e);
    @(posedge i_clk);
    bus <= '0;
  endtask
  task automatic wsync();
    @(posedge i_clk);
    while (sync !== 1'b1)
      @(posedge i_clk);
    s = cyc;
  endtask
  // software writes the period first, then dead time and all three duties
  task automatic setd(logic [2:0][15:0] d, int t);
    wr(tpwm_pkg::OFS_DEAD, t);
    for (int k = 0; k < 3; k++)
      wr(tpwm_pkg::OFS_DUTY0 + 8'(4 * k), {16'h0, d[k]});
  endtask
  task automatic meas(int p1, int p2, int t, logic [2:0][15:0] d);
    logic [5:0][15:0] e;
    repeat (2) @(posedge i_clk);
    for (int k = 0; k < 3; k++)
    begin
      e[k + 3] = 16'(ont(p1, d[k], t, 1) + ont(p2, d[k], t, 1));
      e[k] = 16'(ont(p1, d[k], t, -1) + ont(p2, d[k], t, -1));
    end
    q_on.push_back(e);
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    rd_d <= bus.rd;
    if (rd_d)
      chk("rdata", rdata, q_rd.pop_front());
    if (sync && q_sync.size() > 0)
      chk("sync", cyc, q_sync.pop_front());
    if (done && q_on.size() > 0)
      chk("on", on, q_on.pop_front());
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    logic [2:0][15:0] d;
    int p, q, t;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(tpwm_pkg::OFS_STATE, 32'h0);
    rd(8'h24, 32'h0);
    p = 16 + 2 * int'(xs() % 8);
    // first sync after one and a half periods
    wr(tpwm_pkg::OFS_PERIOD, p);
    q_sync.push_back(w + 1 + p - p / 2 + p);
    q_sync.push_back(w + 1 + p - p / 2 + 3 * p);
    for (int r = 0; r < 2; r++)
    begin
      t = r ? p / 2 + 2 : int'(xs() % 4);
      d = {16'(xs() % 4), 16'h0, 16'(p)};
      setd(d, t);
      wsync();
      wsync();
      meas(p, p, t, d);
      wsync();
    end
    wr(tpwm_pkg::OFS_IRQ_MASK, 32'h1);
    wsync();
    rd(tpwm_pkg::OFS_STATE, 32'h6);
    chk("irq", irq, 1'b1);
    rd(tpwm_pkg::OFS_IRQ_STAT, 32'h3);
    rd(tpwm_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq", irq, 1'b0);
    // double update after a second reset
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    q = 16 + 2 * int'(xs() % 8);
    d = {16'(xs() % 4), 16'(xs() % 4), 16'(xs() % 4)};
    t = int'(xs() % 4);
    wr(tpwm_pkg::OFS_CTRL, 32'h1);
    wr(tpwm_pkg::OFS_PERIOD, p);
    q_sync.push_back(w + 1 + p);
    q_sync.push_back(w + 1 + 3 * p);
    // second half, running, drives still gated
    rd(tpwm_pkg::OFS_STATE, 32'h3);
    setd(d, t);
    wsync();
    wsync();
    meas(p, q, t, d);
    wr(tpwm_pkg::OFS_PERIOD, q);
    q_sync.push_back(s + p + q);
    q_sync.push_back(s + p + 3 * q);
    repeat (3) wsync();
    // clock enable low freezes the timer, so the next sync slips by the frozen cycles
    ce <= 1'b0;
    repeat (40) @(posedge i_clk);
    ce <= 1'b1;
    q_sync.push_back(s + 40 + 2 * q);
    wsync();
    @(posedge i_clk);
    chk("pending", q_sync.size() + q_on.size() + q_rd.size(), 0);
    chk("fault", fault, 1'b0);
    tally_and_finish();
  end
endmodule
